// >>> dram_refresh_ctrl.sv
// Memory controller end: bus access sequencing, block decode and refresh
// Operation
// - Strobe rise starts sequencing, latches address
// - Low five bits column, upper seven row
// - Select low connects data; high floats output
// - Read holds direction high, no store
// - Write mode stores input data into cells
// - Write with select high is refresh
// - Every column refreshed within 2 ms
// - Read-modify-write: select low, then write pulse
// - Sixteen chips form two byte-wide banks
// - Two separately selectable 4K byte blocks
// - Address in first phase, data second
// - Handshake with bus master for refresh
// - External clock normally, internal in standby
// - Synchronise power fail; generate refresh columns
// - RAM output inverted; read path inverts
// - Refresh spread evenly, not burst
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_ctrl #(
    parameter logic [dram_pkg::BLOCK_W-1:0] BLOCK_A = 4'h0,
    parameter logic [dram_pkg::BLOCK_W-1:0] BLOCK_B = 4'h1,
    parameter int INT_CLOCK_DIV   = dram_pkg::INT_CLOCK_CYC,
    parameter int REFRESH_SPACING = dram_pkg::REFRESH_SPACING_CYC
) (
    input  wire logic                          i_clock,
    input  wire logic                          i_sys_rst,
    input  wire logic                          i_mem_clock,
    input  wire logic                          i_power_fail,
    input  wire logic                          i_vma,
    input  wire logic                          i_rw,
    input  wire logic [dram_pkg::BUS_ADDR_W-1:0] i_addr,
    input  wire logic [dram_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                          i_refresh_grant,
    output logic                               o_refresh_req,
    output logic [dram_pkg::DATA_W-1:0]        o_rdata,
    output logic                               o_rdata_valid,
    output logic                               o_busy,
    output logic                               o_standby,
    dram_link_if.ctrl                          link
);
    import dram_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_SETUP     = 3'b001,
        ST_SENSE     = 3'b010,
        ST_WRITE     = 3'b011,
        ST_HOLD      = 3'b100,
        ST_PRECHARGE = 3'b101
    } state_e;

    state_e               state;
    logic [3:0]           cnt;
    logic                 is_refresh;
    logic                 is_write;
    logic [NUM_BANKS-1:0] bank_sel_n;
    logic                 refresh_pending;
    logic [7:0]           int_cnt;
    logic                 int_tick;

    logic                 mclk_s1;
    logic                 mclk_s2;
    logic                 mclk_s3;
    logic                 pf_s1;
    logic                 pf_s2;

    logic                 ce;
    logic [NUM_BANKS-1:0] sel_n;
    logic                 rw;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    din;

    logic                 refresh_due;
    logic [COL_W-1:0]     refresh_col;
    logic                 refresh_start;

    initial begin
        if (BLOCK_A == BLOCK_B) begin
            $error("both banks decode the same 4K block");
        end
        if (INT_CLOCK_DIV < 2 || INT_CLOCK_DIV > 255) begin
            $error("internal clock divider out of range");
        end
        if (READ_CYC <= ACCESS_CYC + 1 || READ_CYC > 15 || SETUP_CYC > 15) begin
            $error("cycle timing does not fit the RAM access time");
        end
    end

    refresh_sched #(
        .SPACING (REFRESH_SPACING)
    ) u_sched (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_advance (refresh_start),
        .o_due     (refresh_due),
        .o_column  (refresh_col)
    );

    // Decode and selection
    wire hit_a = i_addr[BUS_ADDR_W-1:ADDR_W] == BLOCK_A;
    wire hit_b = i_addr[BUS_ADDR_W-1:ADDR_W] == BLOCK_B;
    wire [NUM_BANKS-1:0] hit_sel_n = hit_a ? 2'h2 : 2'h1;
    wire ext_tick = mclk_s2 & ~mclk_s3;
    wire tick = o_standby ? int_tick : ext_tick;
    wire idle = state == ST_IDLE;
    // Standby refreshes on its own; running needs the stolen bus cycle
    assign refresh_start = idle & tick & refresh_pending & (o_standby | i_refresh_grant);
    wire access_start = idle & tick & ~o_standby & ~refresh_start & i_vma & (hit_a | hit_b);
    wire [ADDR_W-1:0] start_addr = refresh_start ? {{(ADDR_W-COL_W){1'b0}}, refresh_col}
                                                 : i_addr[ADDR_W-1:0];
    wire cnt_done = cnt == 4'h0;

    // Pins from outside the clock domain
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_s3 <= 1'b0;
            pf_s1 <= 1'b0;
            pf_s2 <= 1'b0;
            o_standby <= 1'b0;
        end else begin
            mclk_s1 <= i_mem_clock;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
            pf_s1 <= i_power_fail;
            pf_s2 <= pf_s1;
            o_standby <= pf_s2;
        end
    end

    // Internal standby clock
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            int_cnt <= 8'h00;
            int_tick <= 1'b0;
        end else begin
            int_tick <= int_cnt == 8'(INT_CLOCK_DIV - 1);
            int_cnt <= (int_cnt == 8'(INT_CLOCK_DIV - 1)) ? 8'h00 : int_cnt + 8'h01;
        end
    end

    // A slot that falls due as one starts stays pending
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            refresh_pending <= 1'b0;
            o_refresh_req <= 1'b0;
        end else begin
            if (refresh_due) begin
                refresh_pending <= 1'b1;
            end else if (refresh_start) begin
                refresh_pending <= 1'b0;
            end
            o_refresh_req <= (refresh_pending | refresh_due) & ~refresh_start & ~o_standby;
        end
    end

    // Memory cycle sequencer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            is_refresh <= 1'b0;
            is_write <= 1'b0;
            bank_sel_n <= SEL_NONE_N;
            ce <= 1'b0;
            sel_n <= SEL_NONE_N;
            rw <= 1'b1;
            addr <= 12'h000;
            din <= 8'h00;
            o_rdata <= 8'h00;
            o_rdata_valid <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_rdata_valid <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (refresh_start | access_start) begin
                        state <= ST_SETUP;
                        cnt <= 4'(SETUP_CYC - 1);
                        is_refresh <= refresh_start;
                        is_write <= access_start & ~i_rw;
                        bank_sel_n <= refresh_start ? SEL_NONE_N : hit_sel_n;
                        addr <= start_addr;
                        rw <= ~refresh_start;
                        o_busy <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    if (cnt_done) begin
                        ce <= 1'b1;
                        state <= ST_SENSE;
                        cnt <= 4'(READ_CYC - 1);
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ST_SENSE: begin
                    sel_n <= bank_sel_n;
                    if (!cnt_done) begin
                        cnt <= cnt - 4'h1;
                    end else if (is_write) begin
                        din <= i_wdata;
                        rw <= 1'b0;
                        state <= ST_WRITE;
                        cnt <= 4'(WRITE_CYC - 1);
                    end else begin
                        if (!is_refresh) begin
                            o_rdata <= ~link.data_seen;
                            o_rdata_valid <= 1'b1;
                        end
                        state <= ST_HOLD;
                    end
                end
                ST_WRITE: begin
                    if (cnt_done) begin
                        rw <= 1'b1;
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ST_HOLD: begin
                    ce <= 1'b0;
                    sel_n <= SEL_NONE_N;
                    rw <= 1'b1;
                    state <= ST_PRECHARGE;
                    cnt <= 4'(PRECHARGE_CYC - 1);
                end
                ST_PRECHARGE: begin
                    if (cnt_done) begin
                        state <= ST_IDLE;
                        o_busy <= 1'b0;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.chip_enable = ce;
    assign link.array_sel_n = sel_n;
    assign link.rw = rw;
    assign link.addr = addr;
    assign link.din = din;
endmodule
`default_nettype wire

// >>> dram_pkg.sv
// Shared constants for the dynamic RAM array and its refresh controller
package dram_pkg;
    localparam int ADDR_W     = 12;
    localparam int COL_W      = 5;
    localparam int ROW_W      = 7;
    localparam int DATA_W     = 8;
    localparam int NUM_BANKS  = 2;
    localparam int BLOCK_W    = 4;
    localparam int BUS_ADDR_W = 16;
    localparam int WORDS      = 4096;

    localparam int CLK_PERIOD_NS = 50;

    localparam int REFRESH_WINDOW_US  = 2000;
    localparam int REFRESH_COLS       = 32;
    localparam int REFRESH_SPACING_US = 64;
    // Longest allowed spacing, rounded down so 32 slots fit the window
    localparam int REFRESH_SPACING_CYC = REFRESH_WINDOW_US * 1000 / CLK_PERIOD_NS / REFRESH_COLS;

    localparam int ADDR_SETUP_NS   = 200;
    localparam int READ_VALID_NS   = 350;
    localparam int RAM_ACCESS_NS   = 200;
    localparam int WRITE_PULSE_NS  = 150;
    localparam int PRECHARGE_NS    = 100;
    localparam int INT_CLOCK_NS    = 1000;

    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC     = min_cycles(ADDR_SETUP_NS);
    localparam int READ_CYC      = min_cycles(READ_VALID_NS);
    localparam int ACCESS_CYC    = min_cycles(RAM_ACCESS_NS);
    localparam int WRITE_CYC     = min_cycles(WRITE_PULSE_NS);
    localparam int PRECHARGE_CYC = min_cycles(PRECHARGE_NS);
    localparam int INT_CLOCK_CYC = min_cycles(INT_CLOCK_NS);

    localparam logic [NUM_BANKS-1:0] SEL_NONE_N = 2'h3;
endpackage

// >>> dram_link_if.sv
// Link between the controller and the two-bank dynamic RAM array
`timescale 1ns/10ps
`default_nettype none
interface dram_link_if;
    import dram_pkg::*;
    logic                 chip_enable;
    logic [NUM_BANKS-1:0] array_sel_n;
    logic                 rw;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    din;
    logic [DATA_W-1:0]    dout_n;
    logic                 dout_oe_n;
    logic [DATA_W-1:0]    data_seen;

    // Undriven output floats; resolved here as a pulled-up level
    assign data_seen = dout_oe_n ? {DATA_W{1'b1}} : dout_n;

    modport ram (
        input  chip_enable, array_sel_n, rw, addr, din,
        output dout_n, dout_oe_n
    );
    modport ctrl (
        output chip_enable, array_sel_n, rw, addr, din,
        input  data_seen
    );
endinterface
`default_nettype wire

// >>> dram_array.sv
// Two banks of byte-wide 4096-word dynamic RAM, behavioural device end
`timescale 1ns/10ps
`default_nettype none
module dram_array (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    dram_link_if.ram link
);
    import dram_pkg::*;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_SENSE = 2'b01,
        PH_VALID = 2'b10
    } phase_e;

    logic [DATA_W-1:0]    cells [NUM_BANKS][WORDS];
    logic [DATA_W-1:0]    sense [NUM_BANKS];
    logic [DATA_W-1:0]    wdata [NUM_BANKS];
    logic [NUM_BANKS-1:0] write_seen;
    logic                 store_en;
    logic                 ce_d;
    phase_e               phase;
    logic [3:0]           phase_cnt;
    logic [ADDR_W-1:0]    addr_lat;
    logic [DATA_W-1:0]    dout_n;
    logic                 dout_oe_n;

    // Column from the five low bits, row from the seven high bits
    function automatic logic [ADDR_W-1:0] cell_index(input logic [ADDR_W-1:0] a);
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
        col = a[COL_W-1:0];
        row = a[ADDR_W-1:COL_W];
        return {row, col};
    endfunction

    wire ce_rise = link.chip_enable & ~ce_d;
    wire ce_fall = ~link.chip_enable & ce_d;
    wire bank1_sel = ~link.array_sel_n[1];
    wire any_sel = ~(&link.array_sel_n);
    wire [DATA_W-1:0] sel_sense = bank1_sel ? sense[1] : sense[0];

    initial begin
        if (ACCESS_CYC > 15) begin
            $error("access time does not fit the phase counter");
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ce_d <= 1'b0;
            phase <= PH_IDLE;
            phase_cnt <= 4'h0;
            addr_lat <= 12'h000;
            store_en <= 1'b0;
            write_seen <= 2'h0;
        end else begin
            ce_d <= link.chip_enable;
            if (ce_rise) begin
                addr_lat <= link.addr;
                phase <= PH_SENSE;
                phase_cnt <= 4'(ACCESS_CYC - 1);
                store_en <= 1'b0;
                write_seen <= 2'h0;
            end else if (ce_fall) begin
                phase <= PH_IDLE;
            end else if (phase == PH_SENSE) begin
                if (phase_cnt != 4'h0) begin
                    phase_cnt <= phase_cnt - 4'h1;
                end else begin
                    phase <= PH_VALID;
                end
            end
            // Write mode anywhere after the strobe-rise cycle arms the store phase
            if (link.chip_enable & ~ce_rise & ~link.rw) begin
                store_en <= 1'b1;
            end
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (link.chip_enable & ~ce_rise & ~link.rw & ~link.array_sel_n[b]) begin
                    write_seen[b] <= 1'b1;
                end
            end
        end
    end

    // Cell array is not reset: contents survive a controller reset
    always_ff @(posedge i_clock) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (phase == PH_SENSE && phase_cnt == 4'h0) begin
                sense[b] <= cells[b][cell_index(addr_lat)];
            end
            if (link.chip_enable & ~link.rw & ~link.array_sel_n[b]) begin
                wdata[b] <= link.din;
            end
            if (ce_fall & store_en & ~i_sys_rst) begin
                if (write_seen[b]) begin
                    cells[b][cell_index(addr_lat)] <= wdata[b];
                end else begin
                    cells[b][cell_index(addr_lat)] <= sense[b];
                end
            end
        end
    end

    // No store without write mode, so a read leaves cells untouched
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dout_n <= 8'hFF;
            dout_oe_n <= 1'b1;
        end else begin
            dout_n <= ~sel_sense;
            dout_oe_n <= ~(link.chip_enable & any_sel & (phase == PH_VALID));
        end
    end

    assign link.dout_n = dout_n;
    assign link.dout_oe_n = dout_oe_n;
endmodule
`default_nettype wire

// >>> refresh_sched.sv
// Refresh interval timer and refresh column address counter
`timescale 1ns/10ps
`default_nettype none
module refresh_sched #(
    parameter int SPACING = dram_pkg::REFRESH_SPACING_CYC
) (
    input  wire logic                    i_clock,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_advance,
    output logic                         o_due,
    output logic [dram_pkg::COL_W-1:0]   o_column
);
    import dram_pkg::*;

    logic [15:0] interval_cnt;

    initial begin
        if (SPACING < 2 || SPACING > 65535) begin
            $error("refresh spacing out of range");
        end
    end

    // Free-running so a late grant does not stretch later slots
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            interval_cnt <= 16'h0000;
            o_due <= 1'b0;
            o_column <= 5'h00;
        end else begin
            o_due <= 1'b0;
            if (interval_cnt == 16'(SPACING - 1)) begin
                interval_cnt <= 16'h0000;
                o_due <= 1'b1;
            end else begin
                interval_cnt <= interval_cnt + 16'h0001;
            end
            if (i_advance) begin
                o_column <= o_column + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dram_link_props.sv
// Concurrent checks on the controller-to-array link
`timescale 1ns/10ps
`default_nettype none
module dram_link_props (
    input wire logic                           i_clock,
    input wire logic                           i_sys_rst,
    input wire logic                           chip_enable,
    input wire logic [dram_pkg::NUM_BANKS-1:0] array_sel_n,
    input wire logic                           rw,
    input wire logic [dram_pkg::ADDR_W-1:0]    addr,
    input wire logic [dram_pkg::DATA_W-1:0]    din,
    input wire logic                           dout_oe_n
);
    import dram_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    wire logic sel_any;
    assign sel_any = (array_sel_n != SEL_NONE_N);

    // Store phase: three cycles low, then back high before the strobe ends
    sequence s_store_pulse;
        (!rw && chip_enable)[*3] ##1 (rw && chip_enable) ##1 !chip_enable;
    endsequence
    sequence s_refresh_strobe;
        (!sel_any && !rw && addr[11:5] == 7'h00)[*8];
    endsequence

    a_addr_held: assert property (chip_enable |-> $stable(addr))
        else $error("address moved during strobe");
    // Read and refresh strobes last eight cycles, writes add the store pulse
    a_strobe_length: assert property ($rose(chip_enable) |-> chip_enable[*8] ##[1:4] !chip_enable)
        else $error("strobe length out of range");
    a_select_after_strobe: assert property ($rose(sel_any) |-> chip_enable && $past(chip_enable) && rw)
        else $error("bank select not just after strobe in read mode");
    a_store_late: assert property ($fell(rw) && chip_enable |-> $past(chip_enable, 7) && sel_any)
        else $error("write mode entered before read data time");
    a_store_pulse: assert property ($fell(rw) && chip_enable |-> s_store_pulse)
        else $error("write pulse shape wrong");
    a_refresh_form: assert property ($rose(chip_enable) && !rw |-> s_refresh_strobe)
        else $error("refresh strobe not unselected write on row zero");
    a_din_held: assert property (!rw && !$past(rw) && chip_enable |-> $stable(din))
        else $error("write data moved in store phase");
    a_float_unsel: assert property ((!sel_any)[*2] |-> dout_oe_n)
        else $error("array drives data while unselected");
    a_drive_only_sel: assert property ($fell(dout_oe_n) |-> $past(sel_any))
        else $error("array output enabled without select");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench: controller and array joined over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fails++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
    import dram_pkg::*;
    localparam int SPACING = 40;
    logic                  i_clock    = 1'b0;
    logic                  i_sys_rst  = 1'b1;
    logic                  mem_clock  = 1'b0;
    logic                  power_fail = 1'b0;
    logic                  vma        = 1'b0;
    logic                  bus_rw     = 1'b1;
    logic [BUS_ADDR_W-1:0] bus_addr   = 16'h0000;
    logic [DATA_W-1:0]     wdata      = 8'h00;
    logic                  grant      = 1'b0;
    logic                  refresh_req;
    logic [DATA_W-1:0]     rdata;
    logic                  rdata_valid;
    logic                  busy;
    logic                  standby;
    logic                  prev_ce    = 1'b0;
    logic [DATA_W-1:0]     mem [int];
    logic [15:0]           addrs [12];
    int                    fails = 0;
    int                    samples_checked = 0;
    int                    ref_col = 0;
    int                    ref_cnt = 0;

    always #25 i_clock = ~i_clock;

    dram_link_if link ();
    dram_refresh_ctrl #(.INT_CLOCK_DIV(4), .REFRESH_SPACING(SPACING)) i_dram_refresh_ctrl (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mem_clock(mem_clock), .i_power_fail(power_fail),
        .i_vma(vma), .i_rw(bus_rw), .i_addr(bus_addr), .i_wdata(wdata), .i_refresh_grant(grant),
        .o_refresh_req(refresh_req), .o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_busy(busy),
        .o_standby(standby), .link(link));
    dram_array i_dram_array (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link));
    dram_link_props i_dram_link_props (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .chip_enable(link.chip_enable),
        .array_sel_n(link.array_sel_n), .rw(link.rw), .addr(link.addr), .din(link.din),
        .dout_oe_n(link.dout_oe_n));

    // Each refresh strobe must carry the next column in turn
    always @(posedge i_clock) begin
        prev_ce <= link.chip_enable;
        if (link.chip_enable && !prev_ce && !link.rw && !i_sys_rst) begin
            `CHK("refresh column", ref_col[4:0], link.addr[4:0])
            `CHK("refresh row", 7'h00, link.addr[11:5])
            ref_col = (ref_col + 1) % REFRESH_COLS;
            ref_cnt++;
        end
    end

    task automatic tick();
        mem_clock <= 1'b1;
        repeat (4) @(posedge i_clock);
        mem_clock <= 1'b0;
    endtask

    task automatic access(input logic rd, input logic [15:0] a, input logic [7:0] d, input logic en,
                          input logic take);
        int n;
        logic got;
        logic [DATA_W-1:0] seen;
        n = 0;
        got = 1'b0;
        seen = 8'h00;
        vma <= en;
        bus_rw <= rd;
        bus_addr <= a;
        wdata <= d;
        @(posedge i_clock);
        tick();
        while (!busy && n < 10) begin
            @(posedge i_clock);
            n++;
        end
        `CHK("access taken", take, busy)
        n = 0;
        while (busy && n < 40) begin
            @(posedge i_clock);
            n++;
            if (rdata_valid) begin
                got = 1'b1;
                seen = rdata;
            end
        end
        if (take && rd) begin
            `CHK("read strobe", 1'b1, got)
            `CHK("read data", mem[int'(a[12:0])], seen)
        end else if (take) begin
            mem[int'(a[12:0])] = d;
        end
        vma <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic read_all();
        for (int i = 0; i < 12; i++) begin
            access(1'b1, addrs[i], 8'h00, 1'b1, 1'b1);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clock);
        fails++;
        tally_and_finish();
    end

    initial begin
        int n;
        void'($urandom(32'h7612));
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        `CHK("busy after reset", 1'b0, busy)
        `CHK("select after reset", SEL_NONE_N, link.array_sel_n)
        `CHK("standby after reset", 1'b0, standby)
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            addrs[i] = {4'(i % 2), 12'($urandom())};
            access(1'b0, addrs[i], 8'($urandom()), 1'b1, 1'b1);
        end
        read_all();
        access(1'b0, 16'h0ABC, 8'h5A, 1'b1, 1'b1);
        access(1'b0, 16'h1ABC, 8'hA5, 1'b1, 1'b1);
        access(1'b1, 16'h0ABC, 8'h00, 1'b1, 1'b1);
        access(1'b1, 16'h1ABC, 8'h00, 1'b1, 1'b1);
        access(1'b0, 16'h2ABC, 8'hFF, 1'b1, 1'b0);
        access(1'b0, 16'h0ABC, 8'hFF, 1'b0, 1'b0);
        access(1'b1, 16'h0ABC, 8'h00, 1'b1, 1'b1);
        $display("test access done");
        // Wrap the column counter once, granted cycles only
        // A valid read waits on every tick, so refresh must win each one
        grant <= 1'b1;
        vma <= 1'b1;
        bus_rw <= 1'b1;
        bus_addr <= 16'h0ABC;
        repeat (34) begin
            n = 0;
            while (!refresh_req && n < 200) begin
                @(posedge i_clock);
                n++;
            end
            tick();
            `CHK("request cleared", 1'b0, refresh_req)
            `CHK("refresh wins tick", 1'b0, link.rw)
            repeat (20) @(posedge i_clock);
        end
        `CHK("refresh count", 34, ref_cnt)
        grant <= 1'b0;
        vma <= 1'b0;
        read_all();
        $display("test refresh done");
        power_fail <= 1'b1;
        repeat (4) @(posedge i_clock);
        `CHK("standby entered", 1'b1, standby)
        n = ref_cnt;
        repeat (SPACING * 10) @(posedge i_clock);
        `CHK("standby refreshes", 1'b1, (ref_cnt - n) >= 9)
        `CHK("no request in standby", 1'b0, refresh_req)
        power_fail <= 1'b0;
        repeat (30) @(posedge i_clock);
        read_all();
        $display("test standby done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
